// *** core/sdtu_defs.svh ***
// Constants of the secure debug unlock and emulation TAP block
`ifndef SDTU_DEFS_SVH
`define SDTU_DEFS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SDTU_IR_W 5
`define SDTU_CMD_W 10
`define SDTU_SEL_W 7
`define SDTU_KEY_W 64
`define SDTU_DR_W 32

// ----------------------------------------------------------------
// Main instruction register opcodes and capture value
// ----------------------------------------------------------------
`define SDTU_IR_IDCODE 5'h01
`define SDTU_IR_SAMPLE_PRE 5'h02
`define SDTU_IR_SAMPLE 5'h03
`define SDTU_IR_EXTEST 5'h04
`define SDTU_IR_UNLOCK 5'h07
`define SDTU_IR_EMU 5'h11
`define SDTU_IR_BYPASS 5'h1F
`define SDTU_IR_CAPTURE 5'h01

// ----------------------------------------------------------------
// Debug command register layout, reset value and capture value
// ----------------------------------------------------------------
`define SDTU_CMD_RESET 10'h202
`define SDTU_CMD_CAPTURE 10'h001
`define SDTU_CMD_DIR 0
`define SDTU_CMD_EXEC 1
`define SDTU_CMD_EXIT 2
`define SDTU_CMD_SEL_LSB 3

// ----------------------------------------------------------------
// Register-select codes
// ----------------------------------------------------------------
`define SDTU_SEL_ID 7'h02
`define SDTU_SEL_SCAN 7'h10
`define SDTU_SEL_NONE 7'h11
`define SDTU_SEL_STATUS 7'h13
`define SDTU_SEL_BYPASS 7'h7F

`endif

// *** core/sdtu_pkg.sv ***
// Types of the secure debug unlock and emulation TAP block
package sdtu_pkg;

    // TAP controller states
    typedef enum logic [3:0] {
        TS_RST, TS_IDLE, TS_SDR, TS_CDR, TS_SHDR, TS_E1DR, TS_PDR,
        TS_E2DR, TS_UDR, TS_SIR, TS_CIR, TS_SHIR, TS_E1IR, TS_PIR,
        TS_E2IR, TS_UIR
    } sdtu_tap_e;

endpackage

// *** core/sdtu_sync3.sv ***
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module sdtu_sync3 #(
    parameter int unsigned W = 1
) (
    // Destination clock
    input wire logic clk,
    input wire logic rstN,
    input wire logic cen,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    if (W < 1)
    begin : g_bad_width
        $error("sdtu_sync3: W must be at least 1");
    end

    always_comb
    begin
        next_q = (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end

    always_ff @(posedge clk)
    begin
        if (!rstN)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q <= '0;
        end
        else if (cen)
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end
endmodule

// *** core/sdtu_tap_unlock.sv ***
// Password unlock path and emulation TAP with its debug command register
`timescale 1ns/1ns
`include "sdtu_defs.svh"

module sdtu_tap_unlock #(
    parameter int unsigned KEY_W = `SDTU_KEY_W,
    parameter int unsigned DR_W = `SDTU_DR_W,
    // Arbitrary identification value
    parameter logic [`SDTU_DR_W-1:0] DEV_ID = 32'h0000_1001
) (
    // System clock domain
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cen,
    // Test port, clocked by tck
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic porN,
    input wire logic tapCompliancePin,
    output logic tdo,
    output logic tdoOe,
    output logic [KEY_W-1:0] lockCtrl,
    // Device side
    input wire logic sysResetIn,
    input wire logic deviceLocked,
    input wire logic [KEY_W-1:0] storedKey,
    input wire logic storedKeyLegal,
    input wire logic cpuInDebug,
    input wire logic excPending,
    output logic debugPortEnable,
    output logic debugDisableFlag,
    output logic traceTapRelease,
    output logic cpuExecute,
    output logic cpuExitDebug,
    output logic [DR_W-1:0] cpuInstr,
    output logic errFlag
);
    // ------------------------------------------------------------
    // Parameter check and helpers
    // ------------------------------------------------------------
    if (KEY_W < 2 || DR_W != `SDTU_DR_W)
    begin : g_bad_param
        $error("sdtu_tap_unlock: unsupported KEY_W or DR_W");
    end

    function automatic sdtu_pkg::sdtu_tap_e tapNext(
        input sdtu_pkg::sdtu_tap_e s, input logic m);
        unique case (s)
            sdtu_pkg::TS_RST: tapNext = m ? s : sdtu_pkg::TS_IDLE;
            sdtu_pkg::TS_IDLE: tapNext = m ? sdtu_pkg::TS_SDR : s;
            sdtu_pkg::TS_SDR: tapNext = m ? sdtu_pkg::TS_SIR : sdtu_pkg::TS_CDR;
            sdtu_pkg::TS_CDR: tapNext = m ? sdtu_pkg::TS_E1DR : sdtu_pkg::TS_SHDR;
            sdtu_pkg::TS_SHDR: tapNext = m ? sdtu_pkg::TS_E1DR : s;
            sdtu_pkg::TS_E1DR: tapNext = m ? sdtu_pkg::TS_UDR : sdtu_pkg::TS_PDR;
            sdtu_pkg::TS_PDR: tapNext = m ? sdtu_pkg::TS_E2DR : s;
            sdtu_pkg::TS_E2DR: tapNext = m ? sdtu_pkg::TS_UDR : sdtu_pkg::TS_SHDR;
            sdtu_pkg::TS_UDR: tapNext = m ? sdtu_pkg::TS_SDR : sdtu_pkg::TS_IDLE;
            sdtu_pkg::TS_SIR: tapNext = m ? sdtu_pkg::TS_RST : sdtu_pkg::TS_CIR;
            sdtu_pkg::TS_CIR: tapNext = m ? sdtu_pkg::TS_E1IR : sdtu_pkg::TS_SHIR;
            sdtu_pkg::TS_SHIR: tapNext = m ? sdtu_pkg::TS_E1IR : s;
            sdtu_pkg::TS_E1IR: tapNext = m ? sdtu_pkg::TS_UIR : sdtu_pkg::TS_PIR;
            sdtu_pkg::TS_PIR: tapNext = m ? sdtu_pkg::TS_E2IR : s;
            sdtu_pkg::TS_E2IR: tapNext = m ? sdtu_pkg::TS_UIR : sdtu_pkg::TS_SHIR;
            sdtu_pkg::TS_UIR: tapNext = m ? sdtu_pkg::TS_SDR : sdtu_pkg::TS_IDLE;
        endcase
    endfunction

    // Selections that own a 32-bit data path
    function automatic logic isWordSel(input logic [`SDTU_SEL_W-1:0] s);
        isWordSel = (s == `SDTU_SEL_SCAN) || (s == `SDTU_SEL_ID)
            || (s == `SDTU_SEL_STATUS);
    endfunction

    // Instructions a locked device still accepts
    function automatic logic [`SDTU_IR_W-1:0] irFilter(
        input logic [`SDTU_IR_W-1:0] c, input logic open);
        if (open || c == `SDTU_IR_IDCODE || c == `SDTU_IR_SAMPLE_PRE
            || c == `SDTU_IR_SAMPLE || c == `SDTU_IR_EXTEST
            || c == `SDTU_IR_UNLOCK)
            irFilter = c;
        else
            irFilter = `SDTU_IR_BYPASS;
    endfunction

    // ------------------------------------------------------------
    // Test port domain
    // ------------------------------------------------------------
    // Power-on reset or a low compliance pin resets without tck
    logic tapRstN;
    assign tapRstN = porN & tapCompliancePin;

    sdtu_pkg::sdtu_tap_e tapState, next_tapState;
    logic [`SDTU_IR_W-1:0] ir, next_ir, irShift, next_irShift;
    logic [`SDTU_CMD_W-1:0] cmd, next_cmd, cmdShift, next_cmdShift;
    logic [DR_W-1:0] drShift, next_drShift, scanWord, next_scanWord;
    logic [KEY_W-1:0] keyShift, next_keyShift, next_lockCtrl;
    logic emuOwns, next_emuOwns, pausedSeen, next_pausedSeen;
    logic bypassBit, next_bypassBit, holdTog, next_holdTog;
    logic execTog, next_execTog, exitReq, next_exitReq;
    logic tdoNext, unlockedT, lockedT, errT, inDebugT;
    logic unlocked;
    logic [`SDTU_SEL_W-1:0] sel;
    logic selExecOk;

    sdtu_sync3 #(.W(4)) u_sync_tck (
        .clk(tck),
        .rstN(tapRstN),
        .cen(1'b1),
        .d({unlocked, deviceLocked, errFlag, cpuInDebug}),
        .q({unlockedT, lockedT, errT, inDebugT})
    );

    assign sel = cmd[`SDTU_CMD_SEL_LSB +: `SDTU_SEL_W];
    assign selExecOk = (sel == `SDTU_SEL_SCAN)
        || (sel == `SDTU_SEL_NONE);

    always_comb
    begin
        next_tapState = tapNext(tapState, tms);
        next_ir = ir;
        next_irShift = irShift;
        next_cmd = cmd;
        next_cmdShift = cmdShift;
        next_drShift = drShift;
        next_scanWord = scanWord;
        next_keyShift = keyShift;
        next_lockCtrl = lockCtrl;
        next_emuOwns = emuOwns;
        next_pausedSeen = pausedSeen;
        next_bypassBit = bypassBit;
        next_holdTog = holdTog;
        next_execTog = execTog;
        next_exitReq = exitReq;
        unique case (tapState)
            sdtu_pkg::TS_RST:
            begin
                next_ir = `SDTU_IR_IDCODE;
                next_cmd = `SDTU_CMD_RESET;
                next_emuOwns = 1'b0;
                next_keyShift = '0;
                next_lockCtrl = '0;
            end
            sdtu_pkg::TS_CIR:
            begin
                next_irShift = `SDTU_IR_CAPTURE;
                next_cmdShift = `SDTU_CMD_CAPTURE;
            end
            sdtu_pkg::TS_SHIR:
            begin
                if (emuOwns)
                    next_cmdShift = {tdi, cmdShift[`SDTU_CMD_W-1:1]};
                else
                    next_irShift = {tdi, irShift[`SDTU_IR_W-1:1]};
            end
            sdtu_pkg::TS_UIR:
            begin
                if (emuOwns)
                    next_cmd = cmdShift;
                else
                begin
                    next_ir = irFilter(irShift, !lockedT || unlockedT);
                    next_emuOwns = (irShift == `SDTU_IR_EMU)
                        && (!lockedT || unlockedT);
                end
            end
            sdtu_pkg::TS_CDR:
            begin
                next_bypassBit = 1'b0;
                next_pausedSeen = 1'b0;
                if (emuOwns)
                begin
                    unique case (sel)
                        `SDTU_SEL_SCAN: next_drShift = scanWord;
                        `SDTU_SEL_ID: next_drShift = DEV_ID;
                        `SDTU_SEL_STATUS:
                            next_drShift = {30'h0000_0000, errT, inDebugT};
                        default: next_drShift = drShift;
                    endcase
                end
                else if (ir == `SDTU_IR_IDCODE)
                    next_drShift = DEV_ID;
            end
            sdtu_pkg::TS_SHDR:
            begin
                next_bypassBit = tdi;
                if (!emuOwns && ir == `SDTU_IR_UNLOCK)
                    next_keyShift = {tdi, keyShift[KEY_W-1:1]};
                else
                    next_drShift = {tdi, drShift[DR_W-1:1]};
            end
            sdtu_pkg::TS_PDR:
                next_pausedSeen = 1'b1;
            sdtu_pkg::TS_UDR:
            begin
                if (emuOwns)
                begin
                    if (!cmd[`SDTU_CMD_DIR] && sel == `SDTU_SEL_SCAN)
                        next_scanWord = drShift;
                    if (cmd[`SDTU_CMD_EXEC] && selExecOk)
                    begin
                        next_execTog = !execTog;
                        next_exitReq = cmd[`SDTU_CMD_EXIT];
                    end
                    if (pausedSeen)
                        next_emuOwns = 1'b0;
                end
                else if (ir == `SDTU_IR_UNLOCK)
                begin
                    next_lockCtrl = keyShift;
                    next_holdTog = !holdTog;
                end
            end
            default:
            begin
            end
        endcase
    end

    always_ff @(posedge tck or negedge tapRstN)
    begin
        if (!tapRstN)
        begin
            tapState <= sdtu_pkg::TS_RST;
            ir <= `SDTU_IR_IDCODE;
            irShift <= '0;
            cmd <= `SDTU_CMD_RESET;
            cmdShift <= '0;
            drShift <= '0;
            scanWord <= '0;
            keyShift <= '0;
            lockCtrl <= '0;
            emuOwns <= 1'b0;
            pausedSeen <= 1'b0;
            bypassBit <= 1'b0;
            holdTog <= 1'b0;
            execTog <= 1'b0;
            exitReq <= 1'b0;
        end
        else
        begin
            tapState <= next_tapState;
            ir <= next_ir;
            irShift <= next_irShift;
            cmd <= next_cmd;
            cmdShift <= next_cmdShift;
            drShift <= next_drShift;
            scanWord <= next_scanWord;
            keyShift <= next_keyShift;
            lockCtrl <= next_lockCtrl;
            emuOwns <= next_emuOwns;
            pausedSeen <= next_pausedSeen;
            bypassBit <= next_bypassBit;
            holdTog <= next_holdTog;
            execTog <= next_execTog;
            exitReq <= next_exitReq;
        end
    end

    // TDO source follows the active path; pin changes on falling tck
    always_comb
    begin
        if (tapState == sdtu_pkg::TS_SHIR)
            tdoNext = emuOwns ? cmdShift[0] : irShift[0];
        else if (!emuOwns && ir == `SDTU_IR_UNLOCK)
            tdoNext = keyShift[0];
        else if ((emuOwns && isWordSel(sel))
            || (!emuOwns && ir == `SDTU_IR_IDCODE))
            tdoNext = drShift[0];
        else
            tdoNext = bypassBit;
    end

    always_ff @(negedge tck or negedge tapRstN)
    begin
        if (!tapRstN)
        begin
            tdo <= 1'b0;
            tdoOe <= 1'b0;
        end
        else
        begin
            tdo <= tdoNext;
            tdoOe <= (tapState == sdtu_pkg::TS_SHIR)
                || (tapState == sdtu_pkg::TS_SHDR);
        end
    end

    // ------------------------------------------------------------
    // System clock domain
    // ------------------------------------------------------------
    logic holdTogS, execTogS, holdTogLast, execTogLast, sysResetLast;
    logic next_unlocked, next_cpuExecute, next_cpuExitDebug;
    logic next_errFlag, keyEvt, execEvt, sysResetRise, keyMatch;
    logic [DR_W-1:0] next_cpuInstr;

    sdtu_sync3 #(.W(2)) u_sync_ref (
        .clk(ref_clk),
        .rstN(rst_n),
        .cen(cen),
        .d({holdTog, execTog}),
        .q({holdTogS, execTogS})
    );

    assign keyEvt = holdTogS != holdTogLast;
    assign execEvt = execTogS != execTogLast;
    assign sysResetRise = sysResetIn && !sysResetLast;
    // Hold register is stable for many tck edges after its toggle
    assign keyMatch = storedKeyLegal && (lockCtrl == storedKey);

    always_comb
    begin
        next_unlocked = unlocked;
        next_errFlag = errFlag;
        next_cpuExecute = 1'b0;
        next_cpuExitDebug = cpuExitDebug;
        next_cpuInstr = cpuInstr;
        if (sysResetRise)
        begin
            next_unlocked = 1'b0;
            next_errFlag = 1'b0;
        end
        if (keyEvt && sysResetIn && keyMatch)
            next_unlocked = 1'b1;
        if (execEvt && cpuInDebug)
        begin
            next_cpuExecute = 1'b1;
            next_cpuExitDebug = exitReq;
            next_cpuInstr = scanWord;
            if (!exitReq && excPending)
                next_errFlag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            holdTogLast <= 1'b0;
            execTogLast <= 1'b0;
            sysResetLast <= 1'b0;
            unlocked <= 1'b0;
            errFlag <= 1'b0;
            cpuExecute <= 1'b0;
            cpuExitDebug <= 1'b0;
            cpuInstr <= '0;
        end
        else if (cen)
        begin
            holdTogLast <= holdTogS;
            execTogLast <= execTogS;
            sysResetLast <= sysResetIn;
            unlocked <= next_unlocked;
            errFlag <= next_errFlag;
            cpuExecute <= next_cpuExecute;
            cpuExitDebug <= next_cpuExitDebug;
            cpuInstr <= next_cpuInstr;
        end
    end

    assign debugPortEnable = !deviceLocked || unlocked;
    assign debugDisableFlag = deviceLocked && !unlocked;
    assign traceTapRelease = !deviceLocked || unlocked;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence sUpdDrEmu;
        tapState == sdtu_pkg::TS_UDR && emuOwns;
    endsequence

    sequence sPauseThenUpd;
        tapState == sdtu_pkg::TS_PDR ##1 tapState == sdtu_pkg::TS_E2DR
            ##1 tapState == sdtu_pkg::TS_UDR;
    endsequence

    chk_cmd_reset_val: assert property (@(posedge tck) disable iff (!tapRstN)
        tapState == sdtu_pkg::TS_RST |=> cmd == `SDTU_CMD_RESET)
        else $error("command register not at reset value");

    chk_cmd_update_ir: assert property (@(posedge tck) disable iff (!tapRstN)
        tapState == sdtu_pkg::TS_UIR && emuOwns |=> cmd == $past(cmdShift))
        else $error("command register not loaded in Update-IR");

    chk_hold_copy_dr: assert property (@(posedge tck) disable iff (!tapRstN)
        tapState == sdtu_pkg::TS_UDR && !emuOwns && ir == `SDTU_IR_UNLOCK
        |=> lockCtrl == $past(keyShift))
        else $error("hold register not loaded in Update-DR");

    chk_hold_stays: assert property (@(posedge tck) disable iff (!tapRstN)
        !$stable(lockCtrl) |-> $past(tapState) == sdtu_pkg::TS_UDR
        || $past(tapState) == sdtu_pkg::TS_RST)
        else $error("lock-control outputs changed outside update or reset");

    chk_locked_refuse: assert property (@(posedge tck) disable iff (!tapRstN)
        tapState == sdtu_pkg::TS_UIR && !emuOwns && lockedT && !unlockedT
        |=> !emuOwns && ir != `SDTU_IR_EMU)
        else $error("locked device granted the emulation TAP");

    chk_exec_gate: assert property (@(posedge tck) disable iff (!tapRstN)
        $changed(execTog) |-> $past(cmd[`SDTU_CMD_EXEC]) && $past(selExecOk)
        && $past(tapState) == sdtu_pkg::TS_UDR && $past(emuOwns))
        else $error("execute taken outside an allowed Update-DR");

    chk_port_return: assert property (@(posedge tck) disable iff (!tapRstN)
        emuOwns throughout sPauseThenUpd |=> !emuOwns)
        else $error("port not returned after Pause-DR");

    chk_capture_word: assert property (@(posedge tck) disable iff (!tapRstN)
        tapState == sdtu_pkg::TS_CDR && emuOwns && sel == `SDTU_SEL_SCAN
        |=> drShift == $past(scanWord))
        else $error("scan chain not captured in Capture-DR");

    chk_dir_write: assert property (@(posedge tck) disable iff (!tapRstN)
        sUpdDrEmu and cmd[`SDTU_CMD_DIR] |=> $stable(scanWord))
        else $error("read command wrote the scan chain");

    chk_unlock_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cen && keyEvt && sysResetIn && keyMatch |=> unlocked && !debugDisableFlag)
        else $error("matching key did not unlock");

    chk_unlock_bad: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cen && !unlocked && !(keyEvt && sysResetIn && keyMatch) |=> !unlocked)
        else $error("device unlocked without a matching key");

    chk_reset_relock: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cen && sysResetRise && !keyEvt |=> !unlocked)
        else $error("unlock survived a reset");

    chk_exec_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cen && execEvt && cpuInDebug |=> cpuExecute ##1 (!cpuExecute || !cen))
        else $error("execute pulse missing or too long");

    chk_err_preempt: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cen && execEvt && cpuInDebug && !exitReq && excPending |=> errFlag)
        else $error("pre-empted execute not flagged");
endmodule

// *** testbench/sdtu_debugger.sv ***
// Debugger model driving the test port one frame at a time
`timescale 1ns/1ns
module sdtu_debugger (
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Clock stands low between ticks; tdi does not keep its last bit
    task automatic tick(input logic m, input logic d, output logic o);
        begin
            tms = m;
            tdi = d;
            #40 tck = 1'b1;
            o = tdo;
            #20 tdi = ~d;
            #20 tck = 1'b0;
        end
    endtask
    task automatic reset5();
        logic o;
        begin
            // Off-phase start keeps tck unrelated to the system clock
            #7;
            repeat (5) tick(1'b1, 1'b0, o);
            tick(1'b0, 1'b0, o);
        end
    endtask
    // From idle through one scan of n bits and back to idle
    task automatic scan(input logic ir, input logic [63:0] v, input int n,
                        output logic [63:0] q);
        logic o;
        begin
            q = '0;
            #7;
            tick(1'b1, 1'b0, o);
            if (ir)
                tick(1'b1, 1'b0, o);
            tick(1'b0, 1'b0, o);
            tick(1'b0, 1'b0, o);
            for (int i = 0; i < n; i++)
            begin
                tick(i == n - 1, v[i], o);
                q[i] = o;
            end
            tick(1'b1, 1'b0, o);
            tick(1'b0, 1'b0, o);
        end
    endtask
endmodule

// *** testbench/secure_debug_tap_unlock_bench.sv ***
// Self-checking bench of the unlock path and emulation TAP
`timescale 1ns/1ns
module secure_debug_tap_unlock_bench;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic porN = 1'b0;
    logic sysResetIn = 1'b0;
    logic keyOk = 1'b0;
    logic [63:0] key, lockCtrl, q;
    logic [31:0] rnd = 32'h0000003F;
    logic [31:0] cpuInstr, word, seen;
    logic tck, tms, tdi, tdo, portEn, disFlag, trace, exe, exitD, err;
    logic [6:0] sel [4] = '{7'h02, 7'h10, 7'h11, 7'h10};
    int badCount = 0;
    int testsRun = 0;
    int cycles = 0;
    int execs = 0;
    int e = 0;
    int oeHigh = 0;
    logic inDbg = 1'b1;
    logic oe;
    // Tms walk from idle through Pause-DR to Update-DR and back to idle
    logic [7:0] pausePat = 8'h69;
    always #10 ref_clk = ~ref_clk;
    sdtu_debugger dbg (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    sdtu_tap_unlock dut (.ref_clk(ref_clk), .rst_n(rst_n), .cen(1'b1),
        .tck(tck), .tms(tms), .tdi(tdi), .porN(porN),
        .tapCompliancePin(1'b1), .tdo(tdo), .tdoOe(oe), .lockCtrl(lockCtrl),
        .sysResetIn(sysResetIn), .deviceLocked(1'b1), .storedKey(key),
        .storedKeyLegal(keyOk), .cpuInDebug(inDbg), .excPending(1'b1),
        .debugPortEnable(portEn), .debugDisableFlag(disFlag),
        .traceTapRelease(trace), .cpuExecute(exe), .cpuExitDebug(exitD),
        .cpuInstr(cpuInstr), .errFlag(err));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [63:0] cmd(input logic [6:0] s, input logic g);
        return {54'h0, s, s == 7'h11, g, 1'b1};
    endfunction
    task automatic chk(input string n, input logic [63:0] x, logic [63:0] g);
        begin
            testsRun++;
            if (g !== x)
            begin
                badCount++;
                $display("[FAIL] %s expected %h seen %h", n, x, g);
            end
        end
    endtask
    task automatic conclude();
        begin
            $display("checks %0d mismatches %0d", testsRun, badCount);
            if (badCount == 0 && testsRun > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Execute pulses, captured word and the run ceiling
    always @(negedge ref_clk)
    begin
        cycles++;
        if (exe === 1'b1)
        begin
            execs++;
            seen = cpuInstr;
        end
        if (cycles == 20000)
        begin
            badCount++;
            conclude();
        end
    end
    // Rising tck edges that find the data pin driven
    always @(posedge tck)
        oeHigh += (oe === 1'b1);
    initial
    begin
        rnd = lfsr(rnd);
        key = {rnd, lfsr(rnd)};
        word = lfsr(lfsr(rnd));
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        dbg.reset5();
        @(negedge ref_clk);
        porN = 1'b1;
        dbg.reset5();
        chk("portEn", 0, portEn);
        dbg.scan(1, 5'h11, 5, q);
        dbg.scan(0, 8'hA5, 8, q);
        chk("lockedPath", 8'h4A, q);
        @(negedge ref_clk);
        sysResetIn = 1'b1;
        dbg.scan(1, 5'h07, 5, q);
        dbg.scan(0, key, 64, q);
        repeat (20) @(negedge ref_clk);
        chk("illegalKey", 1, disFlag);
        keyOk = 1'b1;
        dbg.scan(0, ~key, 64, q);
        chk("hold", ~key, lockCtrl);
        repeat (20) @(negedge ref_clk);
        chk("wrongKey", 1, disFlag);
        dbg.scan(0, key, 64, q);
        for (int i = 0; i < 40 && disFlag !== 1'b0; i++) @(negedge ref_clk);
        chk("trace", 1, trace & portEn & ~disFlag);
        sysResetIn = 1'b0;
        dbg.reset5();
        chk("holdClr", 0, lockCtrl);
        dbg.scan(1, 5'h11, 5, q);
        dbg.scan(1, cmd(7'h10, 1'b0) - 1, 10, q);
        dbg.scan(0, word, 32, q);
        dbg.scan(1, cmd(7'h10, 1'b0), 10, q);
        oeHigh = 0;
        dbg.scan(0, 0, 32, q);
        chk("word", word, q);
        chk("oeCount", 32, oeHigh);
        chk("oeIdle", 0, oe);
        dbg.scan(1, cmd(7'h02, 1'b0) - 1, 10, q);
        dbg.scan(0, ~word, 32, q);
        dbg.scan(0, 0, 32, q);
        chk("idWord", 32'h00001001, q);
        for (int i = 0; i < 4; i++)
        begin
            if (i == 3)
                inDbg = 1'b0;
            dbg.scan(1, cmd(sel[i], 1'b1), 10, q);
            repeat (10) @(negedge ref_clk);
            chk("early", e, execs);
            dbg.scan(0, 0, 32, q);
            e += (i == 1 || i == 2);
            repeat (20) @(negedge ref_clk);
            chk("execs", e, execs);
            chk("exit", i >= 2, exitD);
        end
        chk("instr", word, seen);
        chk("err", 1, err);
        dbg.scan(1, cmd(7'h13, 1'b0), 10, q);
        dbg.scan(0, 0, 32, q);
        chk("status", 2, q);
        for (int i = 0; i < 8; i++)
            dbg.tick(pausePat[i], 1'b0, q[0]);
        dbg.scan(1, 10'h3F5, 10, q);
        chk("portBack", 10'h2A1, q);
        @(negedge ref_clk);
        sysResetIn = 1'b1;
        repeat (10) @(negedge ref_clk);
        chk("relock", 2, {disFlag, err});
        conclude();
    end
endmodule
